// ### design/gp_timer_32bit_modes.sv
/*
 * General-purpose timer block: two 16-bit halves, 32-bit one-shot and
 * periodic down-count, 32-bit real-time-clock up-count, 16-bit halves.
 * Assumes an APB master on ref_clk and a clock pin synchronous to ref_clk.
 */
`timescale 1ns/10ps
`include "gp_timer_consts.svh"

// What this block does
// - Two 16-bit halves, separate or joined
// - 32-bit configuration acts as one timer
// - Reset leaves block idle, controls cleared
// - Counters and load registers reset to all ones
// - Prescale registers reset to zero
// - Config 0 one-shot/periodic, 1 clock
// - 32-bit load write fills both halves
// - 32-bit count read joins both halves
// - Joined down-counter, mode from first half
// - Enabled counter counts down, reloads after zero
// - One-shot stops and clears enable; periodic continues
// - Zero sets sticky time-out raw flag
// - Masked flag follows raw flag when unmasked
// - Trigger pulse at time-out when enabled
// - Load write while running takes effect next cycle
// - Stall bit plus stall signal freezes counter
// - Clock mode up-counts, first load is one
// - Pin clock divided down to one hertz
// - Match rolls count to zero, keeps counting
// - Match sets clock flags; clear bit clears
// - Stall override keeps clock running
// - Config 4 gives independent 16-bit halves
module gp_timer_32bit_modes
    import gp_timer_pkg::*;
#(
    parameter int unsigned RTC_DIVIDE = `GPT_RTC_PIN_HZ / `GPT_RTC_OUT_HZ
)(
    input  wire logic                   ref_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`GPT_ADDR_W-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   rtcPin,
    input  wire logic                   stallReq,
    output logic                        trigger,
    output logic                        irq
);

    initial
    begin
        if (RTC_DIVIDE < 2 || RTC_DIVIDE > 65536)
            $error("RTC_DIVIDE must lie in 2..65536");
    end

    localparam logic [15:0] DIV_LAST = 16'(RTC_DIVIDE - 1);
    state_s st_ff;
    state_s nxt_st;

    logic        apbWr;
    logic        apbSetupRd;
    logic        addrHit;
    logic [31:0] count32;
    logic [31:0] match32;
    logic [15:0] mis;
    logic [31:0] wd;
    logic [31:0] rdMux;
    logic        rtcTick;
    logic        frozen32;
    logic        frozenRtc;
    logic        evtA;
    logic        evtB;
    logic        evtRtc;
    logic        mode16;

    // Next down-count step of one 16-bit half: {event, enable, count}
    function automatic step16_t step16(input logic en, input logic frz,
                                       input logic [15:0] cnt,
                                       input logic [15:0] load,
                                       input logic oneShot);
        step16_t r;
        r = {1'b0, en, cnt};
        if (en && !frz)
        begin
            if (cnt == `GPT_ZERO16)
                r = {1'b1, !oneShot, load};
            else
                r = {1'b0, en, cnt - 16'h0001};
        end
        return r;
    endfunction

    assign apbWr      = psel && penable && pwrite;
    assign apbSetupRd = psel && !penable && !pwrite;
    assign wd         = pwdata;
    assign count32    = {st_ff.cntB, st_ff.cntA};
    assign match32    = {st_ff.matchB, st_ff.matchA};
    assign mis        = st_ff.ris & st_ff.imr;
    assign mode16     = (st_ff.cfg == `GPT_CFG_16);
    assign frozen32   = stallReq && st_ff.ctl.stallA;
    assign frozenRtc  = stallReq && (st_ff.ctl.stallA || st_ff.ctl.stallB)
                        && !st_ff.ctl.rtcOvr;
    assign rtcTick    = (st_ff.cfg == `GPT_CFG_RTC) && st_ff.ctl.enA && rtcPin
                        && !st_ff.pinPrev && (st_ff.rtcDiv == DIV_LAST);

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addrHit;
    assign prdata  = st_ff.rdData;
    assign trigger = st_ff.trig;
    assign irq     = |mis;

    always_comb
    begin
        addrHit = 1'b1;
        rdMux   = 32'h0000_0000;
        case (paddr)
            `GPT_CFG_OFS:    rdMux = {29'h0, st_ff.cfg};
            `GPT_MODEA_OFS:  rdMux = {30'h0, st_ff.modeA};
            `GPT_MODEB_OFS:  rdMux = {30'h0, st_ff.modeB};
            `GPT_CTL_OFS:
            begin
                rdMux[`GPT_CTL_ENA]    = st_ff.ctl.enA;
                rdMux[`GPT_CTL_STALLA] = st_ff.ctl.stallA;
                rdMux[`GPT_CTL_RTCOVR] = st_ff.ctl.rtcOvr;
                rdMux[`GPT_CTL_OTEA]   = st_ff.ctl.oteA;
                rdMux[`GPT_CTL_ENB]    = st_ff.ctl.enB;
                rdMux[`GPT_CTL_STALLB] = st_ff.ctl.stallB;
                rdMux[`GPT_CTL_OTEB]   = st_ff.ctl.oteB;
            end
            `GPT_IMR_OFS:    rdMux = {16'h0, st_ff.imr};
            `GPT_RIS_OFS:    rdMux = {16'h0, st_ff.ris};
            `GPT_MIS_OFS:    rdMux = {16'h0, mis};
            `GPT_ICR_OFS:    rdMux = 32'h0000_0000;
            `GPT_LOADA_OFS:  rdMux = mode16 ? {16'h0, st_ff.loadA}
                                            : {st_ff.loadB, st_ff.loadA};
            `GPT_LOADB_OFS:  rdMux = {16'h0, st_ff.loadB};
            `GPT_MATCHA_OFS: rdMux = mode16 ? {16'h0, st_ff.matchA} : match32;
            `GPT_MATCHB_OFS: rdMux = {16'h0, st_ff.matchB};
            `GPT_PREA_OFS:   rdMux = {24'h0, st_ff.preA};
            `GPT_PREB_OFS:   rdMux = {24'h0, st_ff.preB};
            `GPT_CNTA_OFS:   rdMux = mode16 ? {16'h0, st_ff.cntA}
                                            : count32;
            `GPT_CNTB_OFS:   rdMux = {16'h0, st_ff.cntB};
            default:         addrHit = 1'b0;
        endcase
    end

    always_comb
    begin
        logic [31:0] nc;
        logic [15:0] setBits;
        logic [15:0] clrBits;
        step16_t     sa;
        step16_t     sb;
        nc      = count32;
        setBits = 16'h0000;
        clrBits = 16'h0000;
        sa      = '0;
        sb      = '0;
        evtA    = 1'b0;
        evtB    = 1'b0;
        evtRtc  = 1'b0;
        nxt_st  = st_ff;

        // Pin edges divided down to the one-second tick
        nxt_st.pinPrev = rtcPin;
        if ((st_ff.cfg == `GPT_CFG_RTC) && st_ff.ctl.enA)
        begin
            if (rtcPin && !st_ff.pinPrev)
                nxt_st.rtcDiv = rtcTick ? 16'h0000
                                        : st_ff.rtcDiv + 16'h0001;
        end
        else
            nxt_st.rtcDiv = 16'h0000;

        case (st_ff.cfg)
            `GPT_CFG_32:
            begin
                // Joined down-counter; second-half mode is ignored
                if (st_ff.ctl.enA && !frozen32)
                begin
                    if (count32 == 32'h0000_0000)
                    begin
                        nc   = {st_ff.loadB, st_ff.loadA};
                        evtA = 1'b1;
                        if (st_ff.modeA == `GPT_MODE_ONESHOT)
                            nxt_st.ctl.enA = 1'b0;
                    end
                    else
                        nc = count32 - 32'h0000_0001;
                end
                nxt_st.cntA = nc[15:0];
                nxt_st.cntB = nc[31:16];
            end
            `GPT_CFG_RTC:
            begin
                if (rtcTick && !frozenRtc)
                begin
                    if (count32 == match32)
                    begin
                        nc     = 32'h0000_0000;
                        evtRtc = 1'b1;
                    end
                    else
                        nc = count32 + 32'h0000_0001;
                end
                nxt_st.cntA = nc[15:0];
                nxt_st.cntB = nc[31:16];
            end
            `GPT_CFG_16:
            begin
                // Halves run on their own modes
                sa = step16(st_ff.ctl.enA, stallReq && st_ff.ctl.stallA,
                            st_ff.cntA, st_ff.loadA,
                            st_ff.modeA == `GPT_MODE_ONESHOT);
                sb = step16(st_ff.ctl.enB, stallReq && st_ff.ctl.stallB,
                            st_ff.cntB, st_ff.loadB,
                            st_ff.modeB == `GPT_MODE_ONESHOT);
                evtA           = sa[17];
                nxt_st.ctl.enA = sa[16];
                nxt_st.cntA    = sa[15:0];
                evtB           = sb[17];
                nxt_st.ctl.enB = sb[16];
                nxt_st.cntB    = sb[15:0];
            end
            default:
            begin
                nxt_st.cntA = st_ff.cntA;
            end
        endcase

        setBits[`GPT_IRQ_TOA] = evtA;
        setBits[`GPT_IRQ_TOB] = evtB;
        setBits[`GPT_IRQ_RTC] = evtRtc;
        nxt_st.trig = (evtA && st_ff.ctl.oteA)
                      || (evtB && st_ff.ctl.oteB);

        // Register writes land after counting so a new load wins
        if (apbWr)
        begin
            case (paddr)
                `GPT_CFG_OFS:
                begin
                    nxt_st.cfg = wd[2:0];
                    if (wd[2:0] == `GPT_CFG_RTC && !st_ff.rtcLoaded)
                    begin
                        nxt_st.cntA      = 16'(`GPT_RTC_FIRST);
                        nxt_st.cntB      = 16'(`GPT_RTC_FIRST >> 16);
                        nxt_st.rtcLoaded = 1'b1;
                    end
                end
                `GPT_MODEA_OFS: nxt_st.modeA = wd[1:0];
                `GPT_MODEB_OFS: nxt_st.modeB = wd[1:0];
                `GPT_CTL_OFS:
                begin
                    nxt_st.ctl.enA    = wd[`GPT_CTL_ENA];
                    nxt_st.ctl.stallA = wd[`GPT_CTL_STALLA];
                    nxt_st.ctl.rtcOvr = wd[`GPT_CTL_RTCOVR];
                    nxt_st.ctl.oteA   = wd[`GPT_CTL_OTEA];
                    nxt_st.ctl.enB    = wd[`GPT_CTL_ENB];
                    nxt_st.ctl.stallB = wd[`GPT_CTL_STALLB];
                    nxt_st.ctl.oteB   = wd[`GPT_CTL_OTEB];
                end
                `GPT_IMR_OFS: nxt_st.imr = wd[15:0] & `GPT_IRQ_BITS;
                `GPT_ICR_OFS: clrBits = wd[15:0] & `GPT_IRQ_BITS;
                `GPT_LOADA_OFS:
                begin
                    nxt_st.loadA = wd[15:0];
                    nxt_st.cntA  = wd[15:0];
                    if (!mode16)
                    begin
                        nxt_st.loadB = wd[31:16];
                        nxt_st.cntB  = wd[31:16];
                    end
                end
                `GPT_LOADB_OFS:
                begin
                    nxt_st.loadB = wd[15:0];
                    if (mode16)
                        nxt_st.cntB = wd[15:0];
                end
                `GPT_MATCHA_OFS:
                begin
                    nxt_st.matchA = wd[15:0];
                    if (!mode16)
                        nxt_st.matchB = wd[31:16];
                end
                `GPT_MATCHB_OFS: nxt_st.matchB = wd[15:0];
                `GPT_PREA_OFS:   nxt_st.preA = wd[7:0];
                `GPT_PREB_OFS:   nxt_st.preB = wd[7:0];
                default:         nxt_st.preA = st_ff.preA;
            endcase
        end

        // Set wins over a clear in the same cycle
        nxt_st.ris = (st_ff.ris & ~clrBits) | setBits;

        if (apbSetupRd)
            nxt_st.rdData = rdMux;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st_ff           <= '0;
            st_ff.cfg       <= `GPT_CFG_32;
            st_ff.cntA      <= `GPT_CNT_RST;
            st_ff.cntB      <= `GPT_CNT_RST;
            st_ff.loadA     <= `GPT_LOAD_RST;
            st_ff.loadB     <= `GPT_LOAD_RST;
            st_ff.preA      <= `GPT_PRE_RST;
            st_ff.preB      <= `GPT_PRE_RST;
        end
        else
            st_ff <= nxt_st;
    end

    // Checks
    logic ctlWr;
    logic loadWr;
    assign ctlWr  = apbWr && (paddr == `GPT_CTL_OFS);
    assign loadWr = apbWr && (paddr == `GPT_LOADA_OFS);

    sequence s_zeroHit;
        st_ff.cfg == `GPT_CFG_32 && st_ff.ctl.enA && !frozen32
        && count32 == 32'h0000_0000;
    endsequence

    sequence s_quiet;
        !(apbWr && (paddr == `GPT_CTL_OFS || paddr == `GPT_LOADA_OFS
          || paddr == `GPT_CFG_OFS));
    endsequence

    property p_timeoutSets;
        @(posedge ref_clk) disable iff (sys_rst)
        s_zeroHit |=> st_ff.ris[`GPT_IRQ_TOA];
    endproperty
    a_timeoutSets: assert property (p_timeoutSets) else $error("time-out flag missing");

    property p_reload;
        @(posedge ref_clk) disable iff (sys_rst)
        s_zeroHit ##0 s_quiet |=> count32 == $past({st_ff.loadB, st_ff.loadA});
    endproperty
    a_reload: assert property (p_reload) else $error("reload value wrong");

    property p_oneShot;
        @(posedge ref_clk) disable iff (sys_rst)
        s_zeroHit ##0 s_quiet ##0 (st_ff.modeA == `GPT_MODE_ONESHOT)
        |=> !st_ff.ctl.enA;
    endproperty
    a_oneShot: assert property (p_oneShot) else $error("one-shot kept running");

    property p_periodic;
        @(posedge ref_clk) disable iff (sys_rst)
        s_zeroHit ##0 s_quiet ##0 (st_ff.modeA != `GPT_MODE_ONESHOT)
        |=> st_ff.ctl.enA ##1 (count32 == $past(count32) - 32'h1
                                || $past(frozen32) || $past(count32) == 32'h0
                                || !$past(st_ff.ctl.enA) || $past(apbWr));
    endproperty
    a_periodic: assert property (p_periodic) else $error("periodic stopped");

    property p_trigger;
        @(posedge ref_clk) disable iff (sys_rst)
        s_zeroHit ##0 st_ff.ctl.oteA |=> trigger ##1 !trigger[*1];
    endproperty
    a_trigger: assert property (p_trigger) else $error("trigger not a pulse");

    property p_stall;
        @(posedge ref_clk) disable iff (sys_rst)
        (st_ff.cfg == `GPT_CFG_32 && frozen32) ##0 s_quiet |=> $stable(count32);
    endproperty
    a_stall: assert property (p_stall) else $error("stalled counter moved");

    property p_rtcMatch;
        @(posedge ref_clk) disable iff (sys_rst)
        (rtcTick && !frozenRtc && count32 == match32) ##0 s_quiet
        |=> count32 == 32'h0000_0000 && st_ff.ris[`GPT_IRQ_RTC];
    endproperty
    a_rtcMatch: assert property (p_rtcMatch) else $error("clock match roll-over wrong");

    property p_clear;
        @(posedge ref_clk) disable iff (sys_rst)
        (apbWr && paddr == `GPT_ICR_OFS && pwdata[`GPT_IRQ_RTC] && !evtRtc)
        |=> !st_ff.ris[`GPT_IRQ_RTC] && !mis[`GPT_IRQ_RTC];
    endproperty
    a_clear: assert property (p_clear) else $error("clock flag not cleared");

    property p_irq;
        @(posedge ref_clk) disable iff (sys_rst)
        irq == |(st_ff.ris & st_ff.imr);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt output mismatch");

    property p_load32;
        @(posedge ref_clk) disable iff (sys_rst)
        (loadWr && !mode16) |=> st_ff.loadB == $past(pwdata[31:16])
                                && count32 == $past(pwdata);
    endproperty
    a_load32: assert property (p_load32) else $error("32-bit load split wrong");

    property p_read32;
        @(posedge ref_clk) disable iff (sys_rst)
        (apbSetupRd && paddr == `GPT_CNTA_OFS && !mode16)
        |=> prdata == $past(count32);
    endproperty
    a_read32: assert property (p_read32) else $error("32-bit count read wrong");

    property p_tickPace;
        @(posedge ref_clk) disable iff (sys_rst)
        rtcTick |=> !rtcTick[*3];
    endproperty
    a_tickPace: assert property (p_tickPace) else $error("one-second tick repeated");

endmodule

// ### design/gp_timer_consts.svh
/*
 * Register offsets, field positions, reset values and counts of the
 * general-purpose timer block. Assumes byte addressing on an APB bus.
 */
`ifndef GP_TIMER_CONSTS_SVH
`define GP_TIMER_CONSTS_SVH

`define GPT_ADDR_W        8
`define GPT_CFG_OFS       8'h00
`define GPT_MODEA_OFS     8'h04
`define GPT_MODEB_OFS     8'h08
`define GPT_CTL_OFS       8'h0c
`define GPT_IMR_OFS       8'h18
`define GPT_RIS_OFS       8'h1c
`define GPT_MIS_OFS       8'h20
`define GPT_ICR_OFS       8'h24
`define GPT_LOADA_OFS     8'h28
`define GPT_LOADB_OFS     8'h2c
`define GPT_MATCHA_OFS    8'h30
`define GPT_MATCHB_OFS    8'h34
`define GPT_PREA_OFS      8'h38
`define GPT_PREB_OFS      8'h3c
`define GPT_CNTA_OFS      8'h48
`define GPT_CNTB_OFS      8'h4c

`define GPT_CFG_32        3'h0
`define GPT_CFG_RTC       3'h1
`define GPT_CFG_16        3'h4
`define GPT_MODE_ONESHOT  2'h1
`define GPT_MODE_PERIODIC 2'h2

`define GPT_CTL_ENA       0
`define GPT_CTL_STALLA    1
`define GPT_CTL_RTCOVR    4
`define GPT_CTL_OTEA      5
`define GPT_CTL_ENB       8
`define GPT_CTL_STALLB    9
`define GPT_CTL_OTEB      13

`define GPT_IRQ_TOA       0
`define GPT_IRQ_RTC       3
`define GPT_IRQ_TOB       8
`define GPT_IRQ_BITS      16'h0109

`define GPT_CNT_RST       16'hffff
`define GPT_LOAD_RST      16'hffff
`define GPT_PRE_RST       8'h00
`define GPT_ZERO16        16'h0000
`define GPT_RTC_FIRST     32'h0000_0001
`define GPT_RTC_PIN_HZ    32768
`define GPT_RTC_OUT_HZ    1

`endif

// ### design/gp_timer_pkg.sv
/*
 * Types of the general-purpose timer block: control fields and the
 * complete state record. Assumes the constants header is on the path.
 */
package gp_timer_pkg;

    typedef struct packed {
        logic enA;
        logic stallA;
        logic rtcOvr;
        logic oteA;
        logic enB;
        logic stallB;
        logic oteB;
    } ctl_s;

    typedef struct packed {
        logic [2:0]  cfg;
        logic [1:0]  modeA;
        logic [1:0]  modeB;
        ctl_s        ctl;
        logic [15:0] imr;
        logic [15:0] ris;
        logic [15:0] loadA;
        logic [15:0] loadB;
        logic [15:0] matchA;
        logic [15:0] matchB;
        logic [7:0]  preA;
        logic [7:0]  preB;
        logic [15:0] cntA;
        logic [15:0] cntB;
        logic [15:0] rtcDiv;
        logic        pinPrev;
        logic        rtcLoaded;
        logic        trig;
        logic [31:0] rdData;
    } state_s;

    typedef logic [17:0] step16_t;

endpackage

// ### testbench/rtc_pin_source.sv
/*
 * Square-wave source standing in for the crystal on the clock pin.
 * Assumes a 10 MHz ref_clk; the pin changes right after ref_clk edges.
 */
`timescale 1ns/10ps
module rtc_pin_source
#(
    parameter int unsigned HALF = 153
)(
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    output logic      rtcPin
);
    int unsigned phase;

    // About 32.768 kHz at 10 MHz, runs free
    always @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            phase  <= 0;
            rtcPin <= 1'b0;
        end
        else if (phase == HALF - 1)
        begin
            phase  <= 0;
            rtcPin <= ~rtcPin;
        end
        else
            phase <= phase + 1;
    end
endmodule

// ### testbench/gp_timer_32bit_modes_test.sv
/*
 * Self-checking bench of the timer block: reset state, 32-bit one-shot
 * and periodic counting, clock mode, flags and 16-bit split, over APB.
 * Assumes the pin source model and the constants header are on the path.
 */
`timescale 1ns/10ps
`include "gp_timer_consts.svh"
module gp_timer_32bit_modes_test;
    localparam int unsigned DIV  = 4;
    localparam int unsigned HALF = 153;

    logic                   ref_clk, sys_rst, psel, penable, pwrite, pready;
    logic                   pslverr, rtcPin, stallReq, trigger, irq, rdErr;
    logic [`GPT_ADDR_W-1:0] paddr;
    logic [31:0]            pwdata, prdata, rd, first;
    int                     errorCnt = 0, nChecks = 0, cyc = 0, n, t0;

    gp_timer_32bit_modes #(.RTC_DIVIDE(DIV)) uut
    (
        .ref_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rtcPin, .stallReq, .trigger, .irq
    );
    rtc_pin_source #(.HALF(HALF)) pinSrc
    (
        .ref_clk, .sys_rst, .rtcPin
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) cyc <= cyc + 1;

    task completeRun();
        if (errorCnt == 0 && nChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task timeOut();
        errorCnt++;
        $display("unexpected at %0t: wait ran out", $time);
        completeRun();
    endtask

    task check32(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            errorCnt++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task checkBit(input logic got, input logic exp);
        check32({31'h0, got}, {31'h0, exp});
    endtask

    task apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        @(posedge ref_clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, addr, data};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
            timeOut();
        rd    = prdata;
        rdErr = pslverr;
        {psel, penable} <= 2'b00;
    endtask

    task wr(input logic [7:0] addr, input logic [31:0] data);
        apb(1'b1, addr, data);
    endtask

    task rdChk(input logic [7:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0);
        check32(rd, exp);
    endtask

    // Waits on irq or on trigger, counting falling edges in n
    task waitFor(input logic useIrq, input int bound);
        n = 0;
        do
        begin
            @(negedge ref_clk);
            n++;
        end
        while ((useIrq ? irq : trigger) !== 1'b1 && n < bound);
        if ((useIrq ? irq : trigger) !== 1'b1)
            timeOut();
    endtask

    task resetState();
        rdChk(`GPT_CFG_OFS, 32'h0);
        rdChk(`GPT_CTL_OFS, 32'h0);
        rdChk(`GPT_LOADA_OFS, 32'hffff_ffff);
        rdChk(`GPT_CNTA_OFS, 32'hffff_ffff);
        rdChk(`GPT_PREA_OFS, 32'h0);
        rdChk(`GPT_PREB_OFS, 32'h0);
        rdChk(8'h40, 32'h0);
        checkBit(rdErr, 1'b1);
        checkBit(irq, 1'b0);
    endtask

    task oneShot();
        wr(`GPT_MODEA_OFS, 32'h1);
        wr(`GPT_IMR_OFS, 32'h1);
        wr(`GPT_CTL_OFS, 32'h21);
        wr(`GPT_LOADA_OFS, 32'h0001_0003);
        apb(1'b0, `GPT_CNTA_OFS, 32'h0);
        checkBit(rd <= 32'h0001_0003 && rd > 32'h0001_0000, 1'b1);
        first = rd;
        apb(1'b0, `GPT_CNTA_OFS, 32'h0);
        check32(first - rd, 32'h3);
        stallReq <= 1'b1;
        wr(`GPT_CTL_OFS, 32'h23);
        apb(1'b0, `GPT_CNTA_OFS, 32'h0);
        first = rd;
        rdChk(`GPT_CNTA_OFS, first);
        wr(`GPT_CTL_OFS, 32'h21);
        stallReq <= 1'b0;
        rdChk(`GPT_LOADB_OFS, 32'h1);
        waitFor(1'b0, 70000);
        checkBit(irq, 1'b1);
        @(negedge ref_clk);
        checkBit(trigger, 1'b0);
        rdChk(`GPT_CTL_OFS, 32'h20);
        rdChk(`GPT_CNTA_OFS, 32'h0001_0003);
        rdChk(`GPT_CNTA_OFS, 32'h0001_0003);
        rdChk(`GPT_MIS_OFS, 32'h1);
        wr(`GPT_ICR_OFS, 32'h0);
        rdChk(`GPT_RIS_OFS, 32'h1);
        wr(`GPT_ICR_OFS, 32'h1);
        rdChk(`GPT_RIS_OFS, 32'h0);
        rdChk(`GPT_ICR_OFS, 32'h0);
        checkBit(irq, 1'b0);
    endtask

    task periodic();
        wr(`GPT_MODEA_OFS, 32'h2);
        wr(`GPT_MODEB_OFS, 32'h1);
        wr(`GPT_IMR_OFS, 32'h0);
        wr(`GPT_LOADA_OFS, 32'h0000_0010);
        wr(`GPT_CTL_OFS, 32'h21);
        waitFor(1'b0, 64);
        waitFor(1'b0, 64);
        check32(32'(n), 32'd17);
        checkBit(irq, 1'b0);
        rdChk(`GPT_CTL_OFS, 32'h21);
        rdChk(`GPT_MIS_OFS, 32'h0);
        wr(`GPT_CTL_OFS, 32'h0);
        wr(`GPT_ICR_OFS, 32'h1);
    endtask

    task rtcMode();
        wr(`GPT_CFG_OFS, 32'h1);
        rdChk(`GPT_CNTA_OFS, 32'h1);
        wr(`GPT_MATCHA_OFS, 32'h2);
        wr(`GPT_IMR_OFS, 32'h8);
        stallReq <= 1'b1;
        wr(`GPT_CTL_OFS, 32'h13);
        waitFor(1'b1, 6000);
        t0 = cyc;
        rdChk(`GPT_CNTA_OFS, 32'h0);
        rdChk(`GPT_MIS_OFS, 32'h8);
        wr(`GPT_ICR_OFS, 32'h8);
        rdChk(`GPT_RIS_OFS, 32'h0);
        waitFor(1'b1, 6000);
        check32(32'(cyc - t0), 32'(3 * DIV * 2 * HALF));
        stallReq <= 1'b0;
    endtask

    task halves();
        wr(`GPT_CTL_OFS, 32'h0);
        wr(`GPT_CFG_OFS, 32'h4);
        wr(`GPT_LOADA_OFS, 32'h1234_0056);
        rdChk(`GPT_LOADA_OFS, 32'h0000_0056);
    endtask

    initial
    begin
        {sys_rst, psel, penable, pwrite, stallReq} = 5'b10000;
        paddr  = '0;
        pwdata = '0;
        repeat (2) @(posedge ref_clk);
        sys_rst <= 1'b0;
        resetState();
        oneShot();
        periodic();
        rtcMode();
        halves();
        completeRun();
    end
endmodule
